// *** idc_decoder.sv ***
`timescale 1ns/100ps
module idc_decoder
    import idc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr_word,
    output logic             instr_ready,
    output idc_ctl_t         ctl,
    output logic             ctl_valid
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] ctrl;
        logic [31:0] last_instr;
        logic        sw_pending;
        logic [31:0] sw_instr;
        idc_state_t  state;
        logic [1:0]  cyc_left;
        logic        instr_ready;
        idc_ctl_t    ctl;
        logic        ctl_valid;
        logic [15:0] count;
    } idc_st_t;

    idc_st_t st_r;
    idc_st_t st_nxt;

    // ------------------------------------------------------------
    // decode function
    // ------------------------------------------------------------
    function automatic idc_ctl_t decode(input logic [31:0] w);
        idc_ctl_t c;
        c = '0;
        if (w[1:0] == IDC_OP_INDIRECT) begin
            c.cls = IDC_CLS_IND;
            c.t_load_from_left_bus   = w[IDC_B_LDT];
            c.alu_left_select        = w[IDC_B_SL];
            c.alu_right_select       = w[IDC_B_SR];
            c.mult_m_load            = w[IDC_B_LDM];
            c.mult_n_load            = w[IDC_B_LDN];
            c.t_load_from_result_bus = w[IDC_B_ZT];
            c.right_bus_source       = w[4:3];
            c.left_bus_source        = w[7:5];
            c.alu_code               = w[14:10];
            c.alu_result_destination = w[16:15];
            c.result_bus_source      = w[19:17];
            c.result_bus_destination = w[30:28];
            // code 10 is undefined and treated as no step
            c.coef_ext_pointer_step  = (w[23:22] == 2'h2) ? IDC_STEP_ZERO
                                                           : w[23:22];
            c.y_pointer_step         = (w[25:24] == 2'h2) ? IDC_STEP_ZERO
                                                           : w[25:24];
            c.x_pointer_step         = (w[27:26] == 2'h2) ? IDC_STEP_ZERO
                                                           : w[27:26];
        end else if (w[2:0] == IDC_OP_DIRECT) begin
            c.cls = IDC_CLS_DIR;
            c.right_bus_source       = w[4:3];
            c.left_bus_source        = w[7:5];
            c.alu_right_select       = w[IDC_B_SR];
            c.alu_code               = w[14:10];
            c.direct_fetch           = 1'b1;
            c.direct_address         = w[27:16];
        end else if (w[4:0] == IDC_OP_IMMED) begin
            c.cls = IDC_CLS_IMM;
            c.left_bus_source        = w[7:5];
            c.alu_left_select        = w[IDC_B_SL];
            c.alu_right_select       = w[IDC_B_SR];
            c.alu_code               = w[14:10];
            c.immediate_to_right_bus = 1'b1;
            c.immediate_value        = w[31:16];
        end else if (w[4:0] == IDC_OP_SHIFT) begin
            c.cls = IDC_CLS_SHIFT;
            c.left_bus_source        = w[7:5];
            c.alu_left_select        = w[IDC_B_SL];
            c.shift_kind             = w[10:9];
            c.shift_amount           = w[14:11];
        end else if (w[4:0] == IDC_OP_BR_IMM) begin
            c.cls = IDC_CLS_BR_IMM;
            c.branch                 = 1'b1;
            c.branch_address         = w[31:16];
        end else if (w[4:0] == IDC_OP_BR_CMP) begin
            c.cls = IDC_CLS_BR_CMP;
            c.branch                 = 1'b1;
            c.branch_computed        = 1'b1;
        end else if (w[4:0] == IDC_OP_SAVE) begin
            c.cls = IDC_CLS_SAVE;
            c.save_store             = 1'b1;
            c.result_bus_source      = w[19:17];
            c.result_bus_destination = w[30:28];
        end else if (w[4:0] == IDC_OP_SETUP) begin
            c.cls = IDC_CLS_SETUP;
            c.j_constant             = w[14:7];
            c.y_circular_flag        = w[IDC_B_JCIRC];
            c.k_constant             = w[27:16];
            c.x_circular_flag        = w[IDC_B_KCIRC];
        end
        return c;
    endfunction : decode

    function automatic logic [1:0] cycles(input idc_class_t k,
                                          input logic cplx);
        logic [1:0] n;
        n = cplx ? IDC_CYC_CPLX : IDC_CYC_REAL;
        if (k == IDC_CLS_BR_IMM || k == IDC_CLS_BR_CMP) begin
            n = IDC_CYC_CPLX;
        end
        return n;
    endfunction : cycles

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic        wr_fire;
        logic [31:0] wmask;
        logic [31:0] w;
        idc_ctl_t    d;
        wr_fire = 1'b0;
        wmask   = '0;
        w       = '0;
        d       = '0;
        st_nxt  = st_r;
        st_nxt.ctl_valid = 1'b0;

        // write channel: address and data taken in any order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.awready = 1'b0;
            st_nxt.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.wready = 1'b0;
            st_nxt.wdata  = s_axi_wdata;
            st_nxt.wstrb  = s_axi_wstrb;
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            wr_fire = 1'b1;
            for (int i = 0; i < 4; i++) begin
                wmask[i*8 +: 8] = {8{st_r.wstrb[i]}};
            end
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = IDC_RESP_OKAY;
            if (st_r.awaddr == IDC_ADDR_INSTR) begin
                st_nxt.sw_instr   = st_r.wdata;
                st_nxt.sw_pending = 1'b1;
            end else if (st_r.awaddr == IDC_ADDR_CTRL) begin
                st_nxt.ctrl = (st_r.ctrl & ~wmask) | (st_r.wdata & wmask);
            end else begin
                st_nxt.bresp = IDC_RESP_SLVERR;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid  = 1'b0;
            st_nxt.aw_got  = 1'b0;
            st_nxt.w_got   = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready  = 1'b1;
        end

        // read channel
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid  = 1'b1;
            st_nxt.rresp   = IDC_RESP_OKAY;
            if (s_axi_araddr == IDC_ADDR_INSTR) begin
                st_nxt.rdata = st_r.last_instr;
            end else if (s_axi_araddr == IDC_ADDR_CTRL) begin
                st_nxt.rdata = st_r.ctrl;
            end else if (s_axi_araddr == IDC_ADDR_STATUS) begin
                st_nxt.rdata = {st_r.count, 8'h00, st_r.cyc_left,
                                st_r.ctl.cls, st_r.sw_pending,
                                st_r.state == IDC_ST_EXEC};
            end else if (s_axi_araddr == IDC_ADDR_CTL0) begin
                st_nxt.rdata = {st_r.ctl.t_load_from_result_bus,
                                st_r.ctl.result_bus_destination,
                                st_r.ctl.x_pointer_step,
                                st_r.ctl.y_pointer_step,
                                st_r.ctl.coef_ext_pointer_step,
                                st_r.ctl.mult_n_load,
                                st_r.ctl.mult_m_load,
                                st_r.ctl.result_bus_source,
                                st_r.ctl.alu_result_destination,
                                st_r.ctl.alu_code,
                                st_r.ctl.alu_right_select,
                                st_r.ctl.alu_left_select,
                                st_r.ctl.left_bus_source,
                                st_r.ctl.right_bus_source,
                                st_r.ctl.t_load_from_left_bus, 2'h0};
            end else if (s_axi_araddr == IDC_ADDR_SETUP) begin
                st_nxt.rdata = {st_r.ctl.x_circular_flag,
                                st_r.ctl.y_circular_flag, 2'h0,
                                st_r.ctl.k_constant, 8'h00,
                                st_r.ctl.j_constant};
            end else begin
                st_nxt.rdata = '0;
                st_nxt.rresp = IDC_RESP_SLVERR;
            end
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid  = 1'b0;
            st_nxt.arready = 1'b1;
        end

        // instruction sequencer: pin stream has priority over software
        case (st_r.state)
            IDC_ST_IDLE: begin
                st_nxt.instr_ready = 1'b1;
                if (instr_valid && st_r.instr_ready) begin
                    w = instr_word;
                end else if (st_r.sw_pending) begin
                    w = st_r.sw_instr;
                    st_nxt.sw_pending = 1'b0;
                end
                if ((instr_valid && st_r.instr_ready) || st_r.sw_pending) begin
                    d = decode(w);
                    st_nxt.ctl        = d;
                    st_nxt.ctl_valid  = 1'b1;
                    st_nxt.last_instr = w;
                    st_nxt.count      = st_r.count + 16'h0001;
                    st_nxt.cyc_left   = cycles(d.cls,
                                          st_r.ctrl[IDC_CTRL_CPLX_BIT]) - 2'h1;
                    if (cycles(d.cls, st_r.ctrl[IDC_CTRL_CPLX_BIT])
                            != IDC_CYC_REAL) begin
                        st_nxt.state       = IDC_ST_EXEC;
                        st_nxt.instr_ready = 1'b0;
                    end
                end
            end
            IDC_ST_EXEC: begin
                st_nxt.instr_ready = 1'b0;
                if (st_r.cyc_left <= 2'h1) begin
                    st_nxt.cyc_left    = 2'h0;
                    st_nxt.state       = IDC_ST_IDLE;
                    st_nxt.instr_ready = 1'b1;
                end else begin
                    st_nxt.cyc_left = st_r.cyc_left - 2'h1;
                end
            end
            default: begin
                st_nxt.state = IDC_ST_IDLE;
            end
        endcase
        if (wr_fire && st_r.awaddr == IDC_ADDR_INSTR &&
                st_nxt.sw_pending == 1'b0) begin
            st_nxt.sw_pending = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r         <= '0;
            st_r.awready <= 1'b1;
            st_r.wready  <= 1'b1;
            st_r.arready <= 1'b1;
            st_r.ctrl    <= IDC_CTRL_RESET;
            st_r.state   <= IDC_ST_IDLE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign instr_ready   = st_r.instr_ready;
    assign ctl           = st_r.ctl;
    assign ctl_valid     = st_r.ctl_valid;

endmodule : idc_decoder

// *** idc_decoder_monitor.sv ***
`timescale 1ns/100ps
module idc_decoder_monitor
    import idc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic        instr_ready,
    input wire idc_ctl_t    ctl,
    input wire logic        ctl_valid
);
    logic        take;
    logic        ind;
    logic        no_mid;
    logic [31:0] w_r;
    assign take   = ce && instr_valid && instr_ready;
    assign ind    = take && instr_word[1:0] == IDC_OP_INDIRECT;
    assign no_mid = instr_word[23:22] != 2'h2 &&
                    instr_word[25:24] != 2'h2 && instr_word[27:26] != 2'h2;
    // word seen at the take edge, for comparison one cycle later
    always_ff @(posedge aclk) begin
        w_r <= instr_word;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------
    // decode checks
    // ----------------
    a_pulse_per_take: assert property (
        1'b1 |=> ctl_valid == $past(take)) else $error("ctl_valid off");
    a_indirect_class: assert property (
        ind |=> ctl.cls == IDC_CLS_IND) else $error("indirect class wrong");
    a_transfer_loads: assert property (
        ind |=> ctl.t_load_from_left_bus == w_r[IDC_B_LDT] &&
        ctl.t_load_from_result_bus == w_r[IDC_B_ZT])
        else $error("transfer load bits wrong");
    a_alu_inputs: assert property (
        ind |=> ctl.alu_left_select == w_r[IDC_B_SL] &&
        ctl.alu_right_select == w_r[IDC_B_SR])
        else $error("alu input select wrong");
    a_mult_loads: assert property (
        ind |=> ctl.mult_m_load == w_r[IDC_B_LDM] &&
        ctl.mult_n_load == w_r[IDC_B_LDN]) else $error("mult loads wrong");
    a_pointer_steps: assert property (
        ind && no_mid |=> {ctl.x_pointer_step, ctl.y_pointer_step,
        ctl.coef_ext_pointer_step} == w_r[27:22])
        else $error("pointer steps wrong");
    a_bus_routes: assert property (
        ind |=> ctl.right_bus_source == w_r[4:3] &&
        ctl.left_bus_source == w_r[7:5] &&
        ctl.alu_result_destination == w_r[16:15] &&
        ctl.result_bus_source == w_r[19:17] &&
        ctl.result_bus_destination == w_r[30:28])
        else $error("bus routing fields wrong");
    a_branch_two_cyc: assert property (
        take && instr_word[4:1] == IDC_OP_BR_IMM[4:1]
        |=> !instr_ready ##1 instr_ready) else $error("branch not 2 cycles");
    a_setup_consts: assert property (
        take && instr_word[4:0] == IDC_OP_SETUP |=>
        ctl.j_constant == w_r[14:7] && ctl.k_constant == w_r[27:16])
        else $error("setup constants wrong");
endmodule : idc_decoder_monitor

// *** idc_pkg.sv ***
package idc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] IDC_ADDR_INSTR  = 8'h00;
    localparam logic [7:0] IDC_ADDR_CTRL   = 8'h04;
    localparam logic [7:0] IDC_ADDR_STATUS = 8'h08;
    localparam logic [7:0] IDC_ADDR_CTL0   = 8'h0c;
    localparam logic [7:0] IDC_ADDR_CTL1   = 8'h10;
    localparam logic [7:0] IDC_ADDR_SETUP  = 8'h14;
    localparam logic [1:0] IDC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] IDC_RESP_SLVERR = 2'h2;
    localparam logic [31:0] IDC_CTRL_RESET = 32'h0000_0000;
    localparam int IDC_CTRL_CPLX_BIT = 0;

    // ------------------------------------------------------------
    // opcode patterns and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] IDC_OP_INDIRECT = 2'h0;
    localparam logic [2:0] IDC_OP_DIRECT   = 3'h2;
    localparam logic [4:0] IDC_OP_IMMED    = 5'h0e;
    localparam logic [4:0] IDC_OP_SHIFT    = 5'h0f;
    localparam logic [4:0] IDC_OP_BR_IMM   = 5'h16;
    localparam logic [4:0] IDC_OP_BR_CMP   = 5'h17;
    localparam logic [4:0] IDC_OP_SAVE     = 5'h1e;
    localparam logic [4:0] IDC_OP_SETUP    = 5'h1f;
    localparam int IDC_B_LDT   = 2;
    localparam int IDC_B_SL    = 8;
    localparam int IDC_B_SR    = 9;
    localparam int IDC_B_LDM   = 20;
    localparam int IDC_B_LDN   = 21;
    localparam int IDC_B_ZT    = 31;
    localparam int IDC_B_JCIRC = 15;
    localparam int IDC_B_KCIRC = 27;
    localparam logic [1:0] IDC_STEP_ZERO = 2'h0;
    localparam logic [1:0] IDC_STEP_INC  = 2'h1;
    localparam logic [1:0] IDC_STEP_DEC  = 2'h3;
    localparam logic [1:0] IDC_CYC_REAL  = 2'h1;
    localparam logic [1:0] IDC_CYC_CPLX  = 2'h2;

    typedef enum logic [3:0] {
        IDC_CLS_NONE   = 4'b0000,
        IDC_CLS_IND    = 4'b0001,
        IDC_CLS_DIR    = 4'b0010,
        IDC_CLS_IMM    = 4'b0011,
        IDC_CLS_SHIFT  = 4'b0100,
        IDC_CLS_BR_IMM = 4'b0101,
        IDC_CLS_BR_CMP = 4'b0110,
        IDC_CLS_SAVE   = 4'b0111,
        IDC_CLS_SETUP  = 4'b1000
    } idc_class_t;

    typedef enum logic [1:0] {
        IDC_ST_IDLE = 2'b00,
        IDC_ST_EXEC = 2'b01
    } idc_state_t;

    // decoded datapath controls
    typedef struct packed {
        idc_class_t cls;
        logic       t_load_from_left_bus;
        logic       t_load_from_result_bus;
        logic       mult_m_load;
        logic       mult_n_load;
        logic       alu_left_select;
        logic       alu_right_select;
        logic [1:0] right_bus_source;
        logic [2:0] left_bus_source;
        logic [4:0] alu_code;
        logic [1:0] alu_result_destination;
        logic [2:0] result_bus_source;
        logic [2:0] result_bus_destination;
        logic [1:0] coef_ext_pointer_step;
        logic [1:0] y_pointer_step;
        logic [1:0] x_pointer_step;
        logic       direct_fetch;
        logic [11:0] direct_address;
        logic       immediate_to_right_bus;
        logic [15:0] immediate_value;
        logic [1:0] shift_kind;
        logic [3:0] shift_amount;
        logic       branch;
        logic       branch_computed;
        logic [15:0] branch_address;
        logic       save_store;
        logic [7:0] j_constant;
        logic       y_circular_flag;
        logic [11:0] k_constant;
        logic       x_circular_flag;
    } idc_ctl_t;

endpackage : idc_pkg

// *** idc_prog_mem.sv ***
`timescale 1ns/100ps
module idc_prog_mem (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        stall,
    input wire logic        instr_ready,
    output logic            instr_valid,
    output logic [31:0]     instr_word
);
    logic [31:0] q[$];
    task automatic push(input logic [31:0] w);
        q.push_back(w);
    endtask : push
    initial begin
        instr_valid = 1'b0;
        instr_word  = 32'h0;
    end
    // ---------------------------------
    // offer words, each held until taken
    // ---------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            instr_valid <= 1'b0;
        end else if (!instr_valid || instr_ready) begin
            if (instr_valid)
                void'(q.pop_front());
            if (q.size() > 0 && !stall) begin
                instr_valid <= 1'b1;
                instr_word  <= q[0];
            end else begin
                instr_valid <= 1'b0;
                instr_word  <= ~instr_word; // idle bus never looks stable
            end
        end
    end
endmodule : idc_prog_mem

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
    import idc_pkg::*;
    localparam logic [31:0] WORDS [10] = '{32'hffff_fffc, 32'h0000_0000,
        32'h5545_a568, 32'h0abc_0f3a, 32'h1234_5a6e, 32'h0000_7a0f,
        32'h00ab_cd16, 32'h0000_0017, 32'h0000_003e, 32'h08c3_d29f};
    logic        aclk, aresetn, ce, stall, instr_valid, instr_ready;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, ctl_valid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, instr_word;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    idc_ctl_t    ctl;
    int          num_errors = 0;
    int          checks = 0;
    idc_decoder idc_decoder_inst (.aclk, .aresetn, .ce, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .instr_valid, .instr_word, .instr_ready, .ctl, .ctl_valid);
    idc_prog_mem idc_prog_mem_inst (.aclk, .aresetn, .stall, .instr_ready,
        .instr_valid, .instr_word);
    // ----------------
    // helpers
    // ----------------
    task automatic give_verdict();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : axi_rd
    task automatic wait_ctl();
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (ctl_valid !== 1'b1 && n < 50);
        check(ctl_valid, 1'b1);
    endtask : wait_ctl
    task automatic check_fields(input logic [31:0] w);
        idc_ctl_t c;
        c = ctl;
        if (w[1:0] == IDC_OP_INDIRECT) begin
            check(c.cls, IDC_CLS_IND);
            check(c.x_pointer_step, w[27:26]);
        end else if (w[2:0] == IDC_OP_DIRECT) begin
            check(c.direct_fetch, 1'b1);
            check(c.direct_address, w[27:16]);
        end else if (w[4:0] == IDC_OP_IMMED) begin
            check(c.immediate_to_right_bus, 1'b1);
            check(c.immediate_value, w[31:16]);
        end else if (w[4:0] == IDC_OP_SHIFT) begin
            check(c.shift_amount, w[14:11]);
            check(c.shift_kind, w[10:9]);
        end else if (w[4:0] == IDC_OP_BR_IMM) begin
            check({c.branch, c.branch_computed}, 2'h2);
            check(c.branch_address, w[31:16]);
        end else if (w[4:0] == IDC_OP_BR_CMP) begin
            check(c.branch_computed, 1'b1);
        end else if (w[4:0] == IDC_OP_SAVE) begin
            check(c.save_store, 1'b1);
        end else begin
            check(c.j_constant, w[14:7]);
            check(c.y_circular_flag, w[15]);
            check(c.k_constant, w[27:16]);
            check(c.x_circular_flag, w[27]);
        end
    endtask : check_fields
    task automatic run_pair(input logic [31:0] w, input logic [1:0] cyc);
        int n;
        idc_prog_mem_inst.push(w);
        idc_prog_mem_inst.push(w);
        wait_ctl();
        check_fields(w);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (ctl_valid !== 1'b1 && n < 20);
        check(n, {30'h0, cyc});
    endtask : run_pair
    // ----------------
    // scenarios
    // ----------------
    task automatic test_reset();
        logic [31:0] d;
        logic [1:0]  r;
        repeat (2) @(negedge aclk);
        check(|ctl, 1'b0);
        check({ctl_valid, instr_ready}, 2'h1);
        axi_rd(IDC_ADDR_CTRL, d, r);
        check(d, IDC_CTRL_RESET);
        axi_rd(8'h10, d, r);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, IDC_RESP_SLVERR});
    endtask : test_reset
    task automatic test_stall();
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge aclk);
        stall <= 1'b1;
        @(negedge aclk);
        idc_prog_mem_inst.push(WORDS[2]);
        repeat (4) @(negedge aclk);
        check(ctl_valid, 1'b0);
        @(posedge aclk);
        stall <= 1'b0;
        wait_ctl();
        check_fields(WORDS[2]);
        axi_rd(IDC_ADDR_CTL0, d, r);
        check(d, {WORDS[2][31:2], 2'h0});
        axi_rd(IDC_ADDR_INSTR, d, r);
        check(d, WORDS[2]);
    endtask : test_stall
    task automatic test_timing(input logic cplx);
        logic [31:0] d;
        logic [1:0]  r;
        logic [1:0]  cyc;
        axi_wr(IDC_ADDR_CTRL, {31'h0, cplx}, r);
        check({30'h0, r}, {30'h0, IDC_RESP_OKAY});
        axi_rd(IDC_ADDR_CTRL, d, r);
        check(d, {31'h0, cplx});
        check({30'h0, r}, {30'h0, IDC_RESP_OKAY});
        for (int i = 0; i < 10; i++) begin
            cyc = cplx ? IDC_CYC_CPLX : IDC_CYC_REAL;
            if (WORDS[i][4:1] == 4'hb)
                cyc = 2'h2;
            run_pair(WORDS[i], cyc);
        end
    endtask : test_timing
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        give_verdict();
    end
    initial begin
        {aresetn, stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, ce, s_axi_wstrb} = {32'h0, 1'b1, 4'hf};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset();
        test_stall();
        test_timing(1'b0);
        test_timing(1'b1);
        give_verdict();
    end
endmodule : tb
bind idc_decoder idc_decoder_monitor idc_decoder_monitor_inst (.aclk(aclk),
    .aresetn(aresetn), .ce(ce), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .ctl(ctl),
    .ctl_valid(ctl_valid));
